// >>> src/cms_top.sv
// cms_top: control-mode selection and write-only three-wire serial configuration port
// assumes: pin inputs are asynchronous to clk; sclk is the host's shift clock, also run with select high outside frames
`timescale 1ns/1ns
`default_nettype none
module cms_top (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic sclk,
    input wire logic serial_select_n,
    input wire logic serial_input_line,
    input wire logic range_or_extctl_strap,
    input wire logic range_or_extctl_strap_float,
    input wire logic output_transition_pin,
    input wire logic output_transition_pin_float,
    input wire logic output_swing_pin,
    input wire logic cal_delay_pin,
    input wire logic ilv_pin,
    output logic extended_mode,
    output cms_pkg::cms_settings_s settings
);
    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic [1:0] rst_sync_q;
    wire rst_n = rst_sync_q[1];
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    // ----------------------------------------------------------------
    // pin input synchronisers: three stages, change taken when 2 and 3 agree
    // ----------------------------------------------------------------
    localparam int NPIN = 7;
    wire [NPIN-1:0] pin_raw = {range_or_extctl_strap_float, ilv_pin, cal_delay_pin,
        output_swing_pin, output_transition_pin_float, output_transition_pin,
        range_or_extctl_strap};
    logic [NPIN-1:0] pin_val;
    genvar g;
    generate
        for (g = 0; g < NPIN; g++) begin : g_pin
            logic [2:0] s_q;
            logic v_q;
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    s_q <= 3'h0;
                    v_q <= 1'b0;
                end else begin
                    s_q <= {s_q[1:0], pin_raw[g]};
                    if (s_q[1] == s_q[2]) begin
                        v_q <= s_q[2];
                    end
                end
            end
            assign pin_val[g] = v_q;
        end
    endgenerate
    wire strap_lvl = pin_val[0];
    wire edge_pin = pin_val[1];
    wire edge_float = pin_val[2];
    wire swing_pin = pin_val[3];
    wire cal_pin = pin_val[4];
    wire ilv_pin_s = pin_val[5];
    wire strap_float = pin_val[6];

    // strap is fixed, so it is caught once after reset release
    // a floating strap selects extended mode, a driven one picks the range
    logic strap_seen_q;
    logic ext_q;
    logic [2:0] strap_wait_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_wait_q <= 3'h0;
            strap_seen_q <= 1'b0;
            ext_q <= 1'b0;
        end else if (!strap_seen_q) begin
            strap_wait_q <= strap_wait_q + 3'h1;
            if (strap_wait_q == 3'h7) begin
                strap_seen_q <= 1'b1;
                ext_q <= strap_float;
            end
        end
    end
    assign extended_mode = ext_q;

    // extended mode level crossed into sclk domain
    logic [1:0] ext_sclk_q;
    always_ff @(posedge sclk or negedge rst_b) begin
        if (!rst_b) begin
            ext_sclk_q <= 2'h0;
        end else begin
            ext_sclk_q <= {ext_sclk_q[0], ext_q};
        end
    end

    // ----------------------------------------------------------------
    // serial shifter on the host's clock
    // ----------------------------------------------------------------
    logic [31:0] shift_q;
    logic [5:0] bit_cnt_q;
    logic wr_tog_q;
    cms_pkg::cms_write_s wr_hold_q;
    wire shift_on = ext_sclk_q[1] && !serial_select_n;
    wire [31:0] frame_next = {shift_q[30:0], serial_input_line};
    wire frame_done = shift_on && (bit_cnt_q == cms_pkg::CNT_LAST);
    wire hdr_ok = frame_next[31:20] == cms_pkg::HDR_PATTERN;
    wire [3:0] fr_addr = frame_next[19:16];
    wire [15:0] fr_data = frame_next[15:0];

    // select high clears the frame count asynchronously
    wire sclk_rst_b = rst_b && !serial_select_n;
    always_ff @(posedge sclk or negedge sclk_rst_b) begin
        if (!sclk_rst_b) begin
            shift_q <= 32'h0;
            bit_cnt_q <= 6'h0;
        end else if (shift_on) begin
            shift_q <= frame_next;
            bit_cnt_q <= frame_done ? 6'h0 : bit_cnt_q + 6'h1;
        end
    end

    always_ff @(posedge sclk or negedge rst_b) begin
        if (!rst_b) begin
            wr_tog_q <= 1'b0;
            wr_hold_q <= '0;
        end else if (frame_done && hdr_ok) begin
            wr_tog_q <= ~wr_tog_q;
            wr_hold_q <= '{addr: fr_addr, data: fr_data};
        end
    end

    // ----------------------------------------------------------------
    // write event crossing: toggle, three flip-flops, edge detect between stages two and three
    // ----------------------------------------------------------------
    logic [2:0] tog_sync_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tog_sync_q <= 3'h0;
        end else begin
            tog_sync_q <= {tog_sync_q[1:0], wr_tog_q};
        end
    end
    wire wr_evt = tog_sync_q[2] ^ tog_sync_q[1];

    // ----------------------------------------------------------------
    // write-only user registers
    // ----------------------------------------------------------------
    logic [15:0] cfg_q, i_ofs_q, i_fsr_q, q_ofs_q, q_fsr_q, ilv_en_q, ilv_crs_q, ilv_fin_q;
    wire [3:0] wa = wr_hold_q.addr;
    wire [15:0] wd = wr_hold_q.data;
    wire we_cfg = wr_evt && wa == cms_pkg::ADDR_CFG;
    wire we_i_ofs = wr_evt && wa == cms_pkg::ADDR_I_OFS;
    wire we_i_fsr = wr_evt && wa == cms_pkg::ADDR_I_FSR;
    wire we_q_ofs = wr_evt && wa == cms_pkg::ADDR_Q_OFS;
    wire we_q_fsr = wr_evt && wa == cms_pkg::ADDR_Q_FSR;
    wire we_ilv_en = wr_evt && wa == cms_pkg::ADDR_ILV_EN;
    wire we_ilv_crs = wr_evt && wa == cms_pkg::ADDR_ILV_CRS;
    wire we_ilv_fin = wr_evt && wa == cms_pkg::ADDR_ILV_FIN;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= cms_pkg::RST_CFG;
            i_ofs_q <= cms_pkg::RST_OFS;
            i_fsr_q <= cms_pkg::RST_FSR;
            q_ofs_q <= cms_pkg::RST_OFS;
            q_fsr_q <= cms_pkg::RST_FSR;
            ilv_en_q <= cms_pkg::RST_ILV_EN;
            ilv_crs_q <= cms_pkg::RST_ILV_CRS;
            ilv_fin_q <= cms_pkg::RST_ILV_FIN;
        end else begin
            // no read path exists for any of these
            if (we_cfg) cfg_q <= wd;
            if (we_i_ofs) i_ofs_q <= wd;
            if (we_i_fsr) i_fsr_q <= wd;
            if (we_q_ofs) q_ofs_q <= wd;
            if (we_q_fsr) q_fsr_q <= wd;
            if (we_ilv_en) ilv_en_q <= wd;
            if (we_ilv_crs) ilv_crs_q <= wd;
            if (we_ilv_fin) ilv_fin_q <= wd;
        end
    end

    // ----------------------------------------------------------------
    // setting selection by control mode
    // ----------------------------------------------------------------
    cms_pkg::cms_settings_s set_d, set_q;
    always_comb begin
        set_d = '0;
        if (ext_q) begin
            set_d.ddr_on = !cfg_q[cms_pkg::CFG_DRD_BIT];
            set_d.sdr_rise_edge = cfg_q[cms_pkg::CFG_EDGE_BIT];
            set_d.swing_full = cfg_q[cms_pkg::CFG_SWING_BIT];
            set_d.clock_phase_90 = cfg_q[cms_pkg::CFG_PHASE_BIT];
            set_d.long_cal_delay = 1'b0;
            set_d.i_fsr_step = i_fsr_q[cms_pkg::ADJ_MSB:cms_pkg::ADJ_LSB];
            set_d.q_fsr_step = q_fsr_q[cms_pkg::ADJ_MSB:cms_pkg::ADJ_LSB];
            set_d.i_ofs_step = i_ofs_q[cms_pkg::ADJ_MSB:cms_pkg::ADJ_LSB];
            set_d.q_ofs_step = q_ofs_q[cms_pkg::ADJ_MSB:cms_pkg::ADJ_LSB];
            set_d.ilv_on = ilv_en_q[cms_pkg::ILV_EN_BIT];
            set_d.ilv_use_q = ilv_en_q[cms_pkg::ILV_QSEL_BIT];
            set_d.ilv_auto_phase = ilv_en_q[cms_pkg::ILV_AUTO_BIT];
            set_d.ilv_coarse = ilv_crs_q;
            set_d.ilv_fine = ilv_fin_q;
        end else begin
            set_d.ddr_on = edge_float;
            set_d.sdr_rise_edge = edge_pin;
            set_d.swing_full = swing_pin;
            set_d.clock_phase_90 = 1'b0;
            set_d.long_cal_delay = cal_pin;
            set_d.i_fsr_step = strap_lvl ? cms_pkg::FSR_STEP_NORMAL
                                         : cms_pkg::FSR_STEP_REDUCED;
            set_d.q_fsr_step = set_d.i_fsr_step;
            set_d.i_ofs_step = cms_pkg::OFS_STEP_NONE;
            set_d.q_ofs_step = cms_pkg::OFS_STEP_NONE;
            set_d.ilv_on = ilv_pin_s;
            set_d.ilv_use_q = 1'b0;
            set_d.ilv_auto_phase = 1'b1;
            set_d.ilv_coarse = 16'h0000;
            set_d.ilv_fine = 16'h0000;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            set_q <= '0;
        end else begin
            set_q <= set_d;
        end
    end
    assign settings = set_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_wr_needs_ext;
        @(posedge clk) disable iff (!rst_n) wr_evt |-> ext_q;
    endproperty
    a_wr_needs_ext: assert property (p_wr_needs_ext) else $error("write in normal mode");

    property p_cfg_update;
        @(posedge clk) disable iff (!rst_n) we_cfg |=> cfg_q == $past(wd);
    endproperty
    a_cfg_update: assert property (p_cfg_update) else $error("config not stored");

    property p_reserved_keep;
        @(posedge clk) disable iff (!rst_n)
            (wr_evt && !(we_cfg || we_i_ofs || we_i_fsr || we_q_ofs || we_q_fsr
            || we_ilv_en || we_ilv_crs || we_ilv_fin)) |=> $stable(cfg_q) && $stable(ilv_en_q);
    endproperty
    a_reserved_keep: assert property (p_reserved_keep) else $error("reserved write changed state");

    property p_ddr_ext;
        @(posedge clk) disable iff (!rst_n) ext_q |=> settings.ddr_on == !$past(cfg_q[10]);
    endproperty
    a_ddr_ext: assert property (p_ddr_ext) else $error("ddr select wrong");

    property p_phase_norm;
        @(posedge clk) disable iff (!rst_n) !ext_q |=> !settings.clock_phase_90;
    endproperty
    a_phase_norm: assert property (p_phase_norm) else $error("phase not zero");

    property p_cal_ext;
        @(posedge clk) disable iff (!rst_n) ext_q |=> !settings.long_cal_delay;
    endproperty
    a_cal_ext: assert property (p_cal_ext) else $error("long delay in extended mode");

    property p_ofs_norm;
        @(posedge clk) disable iff (!rst_n)
            !ext_q |=> settings.i_ofs_step == 9'h000 && settings.q_ofs_step == 9'h000;
    endproperty
    a_ofs_norm: assert property (p_ofs_norm) else $error("offset in normal mode");

    property p_ilv_norm;
        @(posedge clk) disable iff (!rst_n)
            !ext_q |=> !settings.ilv_use_q && settings.ilv_auto_phase;
    endproperty
    a_ilv_norm: assert property (p_ilv_norm) else $error("interleave normal wrong");

    property p_frame_len;
        @(posedge sclk) disable iff (!sclk_rst_b) frame_done |=> bit_cnt_q == 6'h0;
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("frame count not restarted");

    property p_edge_ext;
        @(posedge clk) disable iff (!rst_n) ext_q |=> settings.sdr_rise_edge == $past(cfg_q[8]);
    endproperty
    a_edge_ext: assert property (p_edge_ext) else $error("edge select wrong");

    property p_mode_hold;
        @(posedge clk) disable iff (!rst_n) strap_seen_q |=> strap_seen_q && $stable(ext_q);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("control mode changed");

    property p_ddr_norm;
        @(posedge clk) disable iff (!rst_n) !ext_q |=> settings.ddr_on == $past(edge_float);
    endproperty
    a_ddr_norm: assert property (p_ddr_norm) else $error("normal ddr select wrong");

    property p_swing_ext;
        @(posedge clk) disable iff (!rst_n)
            ext_q |=> settings.swing_full == $past(cfg_q[cms_pkg::CFG_SWING_BIT]);
    endproperty
    a_swing_ext: assert property (p_swing_ext) else $error("swing select wrong");

    property p_swing_norm;
        @(posedge clk) disable iff (!rst_n) !ext_q |=> settings.swing_full == $past(swing_pin);
    endproperty
    a_swing_norm: assert property (p_swing_norm) else $error("normal swing wrong");

    property p_cal_norm;
        @(posedge clk) disable iff (!rst_n) !ext_q |=> settings.long_cal_delay == $past(cal_pin);
    endproperty
    a_cal_norm: assert property (p_cal_norm) else $error("normal delay wrong");

    property p_fsr_norm;
        @(posedge clk) disable iff (!rst_n)
            !ext_q |=> settings.i_fsr_step == ($past(strap_lvl) ? cms_pkg::FSR_STEP_NORMAL
            : cms_pkg::FSR_STEP_REDUCED) && settings.q_fsr_step == settings.i_fsr_step;
    endproperty
    a_fsr_norm: assert property (p_fsr_norm) else $error("normal range wrong");

    property p_fsr_ext;
        @(posedge clk) disable iff (!rst_n)
            ext_q |=> settings.i_fsr_step == $past(i_fsr_q[cms_pkg::ADJ_MSB:cms_pkg::ADJ_LSB])
            && settings.q_fsr_step == $past(q_fsr_q[cms_pkg::ADJ_MSB:cms_pkg::ADJ_LSB]);
    endproperty
    a_fsr_ext: assert property (p_fsr_ext) else $error("range step wrong");

    property p_ofs_ext;
        @(posedge clk) disable iff (!rst_n)
            ext_q |=> settings.i_ofs_step == $past(i_ofs_q[cms_pkg::ADJ_MSB:cms_pkg::ADJ_LSB])
            && settings.q_ofs_step == $past(q_ofs_q[cms_pkg::ADJ_MSB:cms_pkg::ADJ_LSB]);
    endproperty
    a_ofs_ext: assert property (p_ofs_ext) else $error("offset step wrong");

    property p_ilv_ext;
        @(posedge clk) disable iff (!rst_n)
            ext_q |=> settings.ilv_on == $past(ilv_en_q[cms_pkg::ILV_EN_BIT]);
    endproperty
    a_ilv_ext: assert property (p_ilv_ext) else $error("interleave enable wrong");

    property p_hdr_drop;
        @(posedge sclk) disable iff (!rst_b) frame_done && !hdr_ok |=> $stable(wr_tog_q);
    endproperty
    a_hdr_drop: assert property (p_hdr_drop) else $error("bad header frame taken");

    c_frame: cover property (@(posedge sclk) disable iff (!rst_b) frame_done && hdr_ok);
    c_bad_hdr: cover property (@(posedge sclk) disable iff (!rst_b) frame_done && !hdr_ok);
    c_ilv_write: cover property (@(posedge clk) disable iff (!rst_n) we_ilv_en);
    c_cfg_write: cover property (@(posedge clk) disable iff (!rst_n) we_cfg);
    c_norm_mode: cover property (@(posedge clk) disable iff (!rst_n) strap_seen_q && !ext_q);
endmodule : cms_top
`default_nettype wire

// >>> src/cms_pkg.sv
// cms_pkg: constants and carriers for the control-mode and serial configuration block
// assumes: used by cms_top and the bench, referenced with package scope
package cms_pkg;
    // frame layout, most significant bit first
    localparam int FRAME_BITS = 32;
    localparam int HDR_BITS = 12;
    localparam int ADDR_BITS = 4;
    localparam int DATA_BITS = 16;
    localparam logic [11:0] HDR_PATTERN = 12'h001;
    localparam logic [5:0] CNT_LAST = 6'h1f;

    // register addresses
    localparam logic [3:0] ADDR_CFG = 4'h1;
    localparam logic [3:0] ADDR_I_OFS = 4'h2;
    localparam logic [3:0] ADDR_I_FSR = 4'h3;
    localparam logic [3:0] ADDR_Q_OFS = 4'ha;
    localparam logic [3:0] ADDR_Q_FSR = 4'hb;
    localparam logic [3:0] ADDR_ILV_EN = 4'hd;
    localparam logic [3:0] ADDR_ILV_CRS = 4'he;
    localparam logic [3:0] ADDR_ILV_FIN = 4'hf;

    // power-on values
    localparam logic [15:0] RST_CFG = 16'hb2ff;
    localparam logic [15:0] RST_OFS = 16'h007f;
    localparam logic [15:0] RST_FSR = 16'h807f;
    localparam logic [15:0] RST_ILV_EN = 16'h3fff;
    localparam logic [15:0] RST_ILV_CRS = 16'h0000;
    localparam logic [15:0] RST_ILV_FIN = 16'h0000;

    // field positions
    localparam int CFG_SWING_BIT = 9;
    localparam int CFG_EDGE_BIT = 8;
    localparam int CFG_DRD_BIT = 10;
    localparam int CFG_PHASE_BIT = 11;
    localparam int ADJ_LSB = 7;
    localparam int ADJ_MSB = 15;
    localparam int ILV_EN_BIT = 15;
    localparam int ILV_QSEL_BIT = 13;
    localparam int ILV_AUTO_BIT = 14;

    // normal-mode adjust steps for full and reduced range
    localparam logic [8:0] FSR_STEP_NORMAL = 9'h100;
    localparam logic [8:0] FSR_STEP_REDUCED = 9'h000;
    localparam logic [8:0] OFS_STEP_NONE = 9'h000;

    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] data;
    } cms_write_s;

    typedef struct packed {
        logic ddr_on;
        logic sdr_rise_edge;
        logic clock_phase_90;
        logic swing_full;
        logic long_cal_delay;
        logic [8:0] i_fsr_step;
        logic [8:0] q_fsr_step;
        logic [8:0] i_ofs_step;
        logic [8:0] q_ofs_step;
        logic ilv_on;
        logic ilv_use_q;
        logic ilv_auto_phase;
        logic [15:0] ilv_coarse;
        logic [15:0] ilv_fine;
    } cms_settings_s;
endpackage : cms_pkg

// >>> tb/cms_host_model.sv
// cms_host_model: host controller shifting frames into the three-wire port
// assumes: bench calls shift and idle_edges one at a time
`timescale 1ns/1ns
`default_nettype none
module cms_host_model (
    output logic sclk,
    output logic serial_select_n,
    output logic serial_input_line
);
    // ------------------------------
    // shift clock, 6 ns, idle low except during shift and idle_edges
    // ------------------------------
    initial begin
        sclk = 1'b0;
        serial_select_n = 1'b1;
        serial_input_line = 1'b1;
    end

    // edges with select high, data toggling so no stale level is seen
    task automatic idle_edges(input int n);
        repeat (n) begin
            serial_input_line = ~serial_input_line;
            #3 sclk = 1'b1;
            #3 sclk = 1'b0;
        end
    endtask : idle_edges

    // data changes on the falling edge, the device samples on the rising one
    task automatic shift(input logic [31:0] f, input int nbits, input bit release_sel);
        serial_select_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            serial_input_line = f[31-i];
            #3 sclk = 1'b1;
            #3 sclk = 1'b0;
        end
        if (release_sel) begin
            serial_select_n = 1'b1;
            serial_input_line = ~serial_input_line;
        end
    endtask : shift
endmodule : cms_host_model
`default_nettype wire

// >>> tb/cms_top_tb_top.sv
// cms_top_tb_top: self-checking bench for the control-mode and serial configuration block
// assumes: cms_pkg and cms_top compiled first, host model drives the serial pins
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin bad_count++; \
    $display("FAIL %s exp %h got %h", nm, ex, got); end end
module cms_top_tb_top;
    // ------------------------------
    // signals and instances
    // ------------------------------
    logic clk, rst_b, sclk, sel_n, sdi, strap, edge_pin, edge_float, swing_pin, cal_pin, ilv_pin;
    logic extended_mode, strap_float;
    cms_pkg::cms_settings_s settings;
    logic [15:0] regs [16];
    logic [15:0] lf = 16'h002a;
    logic [3:0] ua [8] = '{4'h1, 4'h2, 4'h3, 4'ha, 4'hb, 4'hd, 4'he, 4'hf};
    logic [3:0] rv [8] = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hc};
    int bad_count = 0;
    int samples_checked = 0;

    cms_host_model host_u (.sclk(sclk), .serial_select_n(sel_n), .serial_input_line(sdi));
    cms_top dut_u (.clk(clk), .rst_b(rst_b), .sclk(sclk), .serial_select_n(sel_n),
        .serial_input_line(sdi), .range_or_extctl_strap(strap),
        .range_or_extctl_strap_float(strap_float),
        .output_transition_pin(edge_pin), .output_transition_pin_float(edge_float),
        .output_swing_pin(swing_pin), .cal_delay_pin(cal_pin), .ilv_pin(ilv_pin),
        .extended_mode(extended_mode), .settings(settings));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ------------------------------
    // helpers
    // ------------------------------
    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : nxt

    function automatic cms_pkg::cms_settings_s exp_ext();
        cms_pkg::cms_settings_s s;
        s.ddr_on = ~regs[1][10];
        s.sdr_rise_edge = regs[1][8];
        s.clock_phase_90 = regs[1][11];
        s.swing_full = regs[1][9];
        s.long_cal_delay = 1'b0;
        s.i_fsr_step = regs[3][15:7];
        s.q_fsr_step = regs[11][15:7];
        s.i_ofs_step = regs[2][15:7];
        s.q_ofs_step = regs[10][15:7];
        s.ilv_on = regs[13][15];
        s.ilv_use_q = regs[13][13];
        s.ilv_auto_phase = regs[13][14];
        s.ilv_coarse = regs[14];
        s.ilv_fine = regs[15];
        return s;
    endfunction : exp_ext

    task automatic pins(input logic [4:0] v);
        @(posedge clk);
        #1 {edge_pin, edge_float, swing_pin, cal_pin, ilv_pin} = v;
    endtask : pins

    task automatic do_reset(input logic fl, input logic lv);
        @(posedge clk);
        #1 rst_b = 1'b0;
        strap_float = fl;
        strap = lv;
        repeat (10) @(posedge clk);
        #1 rst_b = 1'b1;
        foreach (regs[i]) regs[i] = 16'h0000;
        regs[1] = 16'hb2ff;
        regs[2] = 16'h007f;
        regs[10] = 16'h007f;
        regs[3] = 16'h807f;
        regs[11] = 16'h807f;
        regs[13] = 16'h3fff;
        repeat (20) @(posedge clk);
        host_u.idle_edges(4);
    endtask : do_reset

    // write one frame; regs follows only mapped addresses and a correct header
    task automatic wr(input logic [11:0] h, input logic [3:0] a, input logic [15:0] d,
            input bit keep);
        host_u.shift({h, a, d}, 32, !keep);
        if (h == 12'h001 && a inside {ua}) regs[a] = d;
        if (!keep) begin
            repeat (8) @(posedge clk);
            #1;
        end
    endtask : wr

    task automatic chk_ext(input string nm);
        `CHK(nm, exp_ext(), settings)
    endtask : chk_ext

    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done

    initial begin
        #300000;
        bad_count++;
        test_done();
    end

    // ------------------------------
    // tests
    // ------------------------------
    initial begin
        logic [15:0] d;
        logic [3:0] a;
        logic [8:0] fs;
        rst_b = 1'b0;
        strap = 1'b1;
        strap_float = 1'b1;
        {edge_pin, edge_float, swing_pin, cal_pin, ilv_pin} = 5'h1f;
        do_reset(1'b1, 1'b1);
        `CHK("mode", 1'b1, extended_mode)
        chk_ext("defaults");
        $display("test defaults done");
        // first configuration, all eight back to back under one select
        for (int i = 0; i < 8; i++) wr(12'h001, ua[i], regs[ua[i]], i < 7);
        chk_ext("first config");
        $display("test first_config done");
        for (int i = 0; i < 16; i++) begin
            lf = nxt(lf);
            a = ua[lf[2:0]];
            d = nxt(lf);
            pins(lf[4:0]);
            if (a == 4'h1) begin
                wr(12'h001, 4'hd, regs[13] & 16'h7fff, 1'b1);
                d = (d & 16'h0f00) | 16'hb0ff;
                if (!d[10]) d[8] = 1'b0;
            end
            wr(12'h001, a, d, 1'b0);
            chk_ext("random write");
        end
        $display("test random done");
        for (int i = 0; i < 8; i++) begin
            lf = nxt(lf);
            wr(12'h001, rv[i], lf, 1'b0);
            chk_ext("reserved");
        end
        wr(12'h003, 4'h2, 16'hff80, 1'b0);
        chk_ext("bad header");
        host_u.shift({12'h001, 4'h2, 16'hff80}, 20, 1'b1);
        repeat (8) @(posedge clk);
        #1;
        chk_ext("aborted frame");
        wr(12'h001, 4'h2, 16'h5a80, 1'b0);
        chk_ext("after abort");
        $display("test refusals done");
        for (int m = 0; m < 2; m++) begin
            do_reset(1'b0, m[0]);
            fs = m[0] ? cms_pkg::FSR_STEP_NORMAL : cms_pkg::FSR_STEP_REDUCED;
            `CHK("mode", 1'b0, extended_mode)
            for (int i = 0; i < 3; i++) begin
                lf = nxt(lf);
                pins(lf[4:0]);
                host_u.shift({12'h001, 4'h1, 16'hbcff}, 32, 1'b1);
                repeat (10) @(posedge clk);
                #1;
                `CHK("ddr", edge_float, settings.ddr_on)
                if (!edge_float) `CHK("edge", edge_pin, settings.sdr_rise_edge)
                `CHK("phase", 1'b0, settings.clock_phase_90)
                `CHK("swing", swing_pin, settings.swing_full)
                `CHK("cal", cal_pin, settings.long_cal_delay)
                `CHK("fsr", fs, settings.i_fsr_step)
                `CHK("fsr q", fs, settings.q_fsr_step)
                `CHK("ofs", 9'h000, settings.i_ofs_step)
                `CHK("ilv", ilv_pin, settings.ilv_on)
                `CHK("ilv q", 1'b0, settings.ilv_use_q)
                `CHK("ilv auto", 1'b1, settings.ilv_auto_phase)
            end
        end
        $display("test normal_mode done");
        test_done();
    end
endmodule : cms_top_tb_top
`undef CHK
`default_nettype wire
